/* File: design/cdm_debug_ctrl.v */
// debug mode controller: serial tool port, halt/wait/exception control,
// resource and cache access, breakpoints, and always-on trace output.
// assumes the core clock clk; the test port clock is sampled, not used.
`timescale 1ns/1ps
`default_nettype none
`include "cdm_debug_map.vh"

module cdm_debug_ctrl #(
	parameter TW     = 32,
	parameter TDEPTH = 16,
	parameter TAW    = 4
) (
	input  wire          clk,
	input  wire          sys_rst,
	// test access port
	input  wire          tck,
	input  wire          tms,
	input  wire          tdi,
	output wire          tdo,
	output wire          tdo_oe,
	// core control
	input  wire          debug_event,
	input  wire          irq_in,
	input  wire          isr_done,
	input  wire          insn_retired,
	output wire          core_halt,
	output wire          core_in_wait,
	output reg           dbg_exc,
	output reg           irq_take,
	output reg           timer_freeze,
	output wire [1:0]    dbg_mode,
	// core resource access
	output reg           res_we,
	output reg           res_re,
	output reg  [3:0]    res_idx,
	output reg  [31:0]   res_wdata,
	input  wire [31:0]   res_rdata,
	input  wire          res_ack,
	// breakpoints
	output reg           hw_bp_en,
	output reg  [31:0]   hw_bp_addr,
	output reg           sw_bp_en,
	// instruction cache loading
	output reg           ic_we,
	output reg  [31:0]   ic_addr,
	output reg  [31:0]   ic_data,
	// trace
	input  wire          trc_in_valid,
	output wire          trc_in_ready,
	input  wire [TW-1:0] trc_in_data,
	output wire          trc_valid,
	input  wire          trc_ready,
	output wire [TW-1:0] trc_data,
	output reg           trc_trigger
);

	// ------------------------------------------------------------------
	// states, one-hot
	// ------------------------------------------------------------------
	localparam [4:0] ST_RUN  = 5'h01;
	localparam [4:0] ST_STOP = 5'h02;
	localparam [4:0] ST_WAIT = 5'h04;
	localparam [4:0] ST_STEP = 5'h08;
	localparam [4:0] ST_ISR  = 5'h10;

	reg  [4:0]  st_q;
	reg  [4:0]  st_d;
	reg  [4:0]  ret_q;
	reg  [1:0]  mode_q;
	reg         tck_s1_q, tck_s2_q, tck_s3_q;
	reg         tms_s1_q, tms_s2_q, tms_s3_q;
	reg         tdi_s1_q, tdi_s2_q;
	reg  [39:0] sh_in_q;
	reg  [39:0] sh_out_q;
	reg  [5:0]  cnt_q;
	reg         tdo_q;
	reg  [31:0] rd_q;
	reg         rd_busy_q;
	reg         go_q;
	reg         step_q;

	// halted means stop or wait; used by the state machine and commands
	function is_halted;
		input [4:0] s;
		begin
			is_halted = (s == ST_STOP) || (s == ST_WAIT);
		end
	endfunction

	assign core_halt    = is_halted(st_q);
	assign core_in_wait = (st_q == ST_WAIT);
	assign dbg_mode     = mode_q;
	assign tdo          = tdo_q;
	assign tdo_oe       = tms_s2_q;

	// ------------------------------------------------------------------
	// test port sampling: two flops each before any logic
	// ------------------------------------------------------------------
	always @(posedge clk) begin
		if (sys_rst) begin
			tck_s1_q <= 1'b0;
			tck_s2_q <= 1'b0;
			tck_s3_q <= 1'b0;
			tms_s1_q <= 1'b0;
			tms_s2_q <= 1'b0;
			tms_s3_q <= 1'b0;
			tdi_s1_q <= 1'b0;
			tdi_s2_q <= 1'b0;
		end else begin
			tck_s1_q <= tck;
			tck_s2_q <= tck_s1_q;
			tck_s3_q <= tck_s2_q;
			tms_s1_q <= tms;
			tms_s2_q <= tms_s1_q;
			tms_s3_q <= tms_s2_q;
			tdi_s1_q <= tdi;
			tdi_s2_q <= tdi_s1_q;
		end
	end

	wire tck_rise  = tck_s2_q && !tck_s3_q;
	wire tck_fall  = !tck_s2_q && tck_s3_q;
	wire frm_start = tms_s2_q && !tms_s3_q;
	wire frm_end   = !tms_s2_q && tms_s3_q;
	// a frame counts only when exactly its full length was shifted
	wire cmd_go    = frm_end && (cnt_q == `CDM_FRAME_LEN);
	wire [3:0]  op   = sh_in_q[`CDM_OP_MSB:`CDM_OP_LSB];
	wire [3:0]  idx  = sh_in_q[`CDM_IDX_MSB:`CDM_IDX_LSB];
	wire [31:0] data = sh_in_q[`CDM_DATA_MSB:`CDM_DATA_LSB];

	// ------------------------------------------------------------------
	// frame shifter: input on tck rise, output on tck fall
	// ------------------------------------------------------------------
	always @(posedge clk) begin
		if (sys_rst) begin
			sh_in_q  <= 40'h0000000000;
			sh_out_q <= 40'h0000000000;
			cnt_q    <= 6'h00;
			tdo_q    <= 1'b0;
		end else if (frm_start) begin
			// status rides in the top byte, last read word below
			sh_out_q <= {2'h0, st_q[4:0], rd_busy_q, rd_q};
			cnt_q    <= 6'h00;
		end else if (tms_s2_q) begin
			if (tck_rise) begin
				sh_in_q <= {tdi_s2_q, sh_in_q[39:1]};
				if (cnt_q != 6'h3F)
					cnt_q <= cnt_q + 6'h01;
			end
			if (tck_fall) begin
				tdo_q    <= sh_out_q[0];
				sh_out_q <= {1'b0, sh_out_q[39:1]};
			end
		end
	end

	// ------------------------------------------------------------------
	// command execution: settings, access, cache load
	// ------------------------------------------------------------------
	always @(posedge clk) begin
		if (sys_rst) begin
			mode_q       <= `CDM_MODE_RST;
			timer_freeze <= 1'b0;
			hw_bp_en     <= 1'b0;
			hw_bp_addr   <= `CDM_WORD_RST;
			sw_bp_en     <= 1'b0;
			ic_we        <= 1'b0;
			ic_addr      <= `CDM_WORD_RST;
			ic_data      <= `CDM_WORD_RST;
			res_we       <= 1'b0;
			res_re       <= 1'b0;
			res_idx      <= 4'h0;
			res_wdata    <= `CDM_WORD_RST;
			rd_q         <= `CDM_WORD_RST;
			rd_busy_q    <= 1'b0;
			go_q         <= 1'b0;
			step_q       <= 1'b0;
		end else begin
			ic_we  <= 1'b0;
			res_we <= 1'b0;
			go_q   <= 1'b0;
			step_q <= 1'b0;
			// a read holds its strobe until the core answers
			if (res_re && res_ack) begin
				res_re    <= 1'b0;
				rd_busy_q <= 1'b0;
				rd_q      <= res_rdata;
			end
			if (cmd_go) begin
				case (op)
				`CDM_OP_MODE: begin
					mode_q <= data[1:0];
				end
				`CDM_OP_RESUME: begin
					go_q <= is_halted(st_q);
				end
				`CDM_OP_STEP: begin
					step_q <= is_halted(st_q);
				end
				`CDM_OP_REG_WR: begin
					res_we    <= 1'b1;
					res_idx   <= idx;
					res_wdata <= data;
				end
				`CDM_OP_REG_RD: begin
					if (!rd_busy_q) begin
						res_re    <= 1'b1;
						rd_busy_q <= 1'b1;
						res_idx   <= idx;
					end
				end
				`CDM_OP_FREEZE: begin
					timer_freeze <= data[0];
				end
				`CDM_OP_HW_BP: begin
					hw_bp_en   <= idx[0];
					hw_bp_addr <= data;
				end
				`CDM_OP_SW_BP: begin
					sw_bp_en <= data[0];
				end
				`CDM_OP_IC_ADDR: begin
					ic_addr <= data;
				end
				`CDM_OP_IC_WR: begin
					ic_we   <= 1'b1;
					ic_data <= data;
				end
				default: begin
				end
				endcase
			end
			// cache loads walk word by word so a burst needs one address
			if (ic_we)
				ic_addr <= ic_addr + 32'h00000004;
		end
	end

	// ------------------------------------------------------------------
	// execution state machine
	// ------------------------------------------------------------------
	always @* begin
		st_d = st_q;
		case (st_q)
		ST_RUN: begin
			if (debug_event && mode_q == `CDM_MODE_EXT)
				st_d = ST_STOP;
			else if (debug_event && mode_q == `CDM_MODE_WAIT)
				st_d = ST_WAIT;
		end
		ST_STOP: begin
			if (step_q)
				st_d = ST_STEP;
			else if (go_q)
				st_d = ST_RUN;
		end
		ST_WAIT: begin
			// commands first: an interrupt is taken only when no step or resume is pending
			if (step_q)
				st_d = ST_STEP;
			else if (go_q)
				st_d = ST_RUN;
			else if (irq_in)
				st_d = ST_ISR;
		end
		ST_STEP: begin
			if (insn_retired)
				st_d = ret_q;
		end
		ST_ISR: begin
			if (isr_done)
				st_d = ST_WAIT;
		end
		default: begin
			st_d = ST_RUN;
		end
		endcase
	end

	// ------------------------------------------------------------------
	// state register, return state for a step, event pulses
	// ------------------------------------------------------------------
	always @(posedge clk) begin
		if (sys_rst) begin
			st_q        <= ST_RUN;
			ret_q       <= ST_STOP;
			dbg_exc     <= 1'b0;
			irq_take    <= 1'b0;
			trc_trigger <= 1'b0;
		end else begin
			st_q <= st_d;
			if (is_halted(st_q) && step_q)
				ret_q <= st_q;
			// internal mode hands the event to the handler vector
			dbg_exc  <= (st_q == ST_RUN) && debug_event &&
				(mode_q == `CDM_MODE_INT);
			irq_take <= (st_q == ST_WAIT) && (st_d == ST_ISR);
			// trace capture trigger fires in any enabled mode
			trc_trigger <= debug_event &&
				(mode_q != `CDM_MODE_OFF);
		end
	end

	// ------------------------------------------------------------------
	// trace path: always on; tool back-pressure reaches the core
	// ------------------------------------------------------------------
	cdm_fifo #(
		.WIDTH (TW),
		.DEPTH (TDEPTH),
		.AW    (TAW)
	) u_trace_fifo (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.in_valid  (trc_in_valid),
		.in_ready  (trc_in_ready),
		.in_data   (trc_in_data),
		.out_valid (trc_valid),
		.out_ready (trc_ready),
		.out_data  (trc_data)
	);

endmodule // cdm_debug_ctrl

`default_nettype wire

/* File: design/cdm_debug_map.vh */
// constants for the debug mode controller: frame layout, command codes,
// mode codes and reset values; assumes inclusion by bare name
`ifndef CDM_DEBUG_MAP_VH
`define CDM_DEBUG_MAP_VH

// ----------------------------------------------------------------------
// serial frame layout (lsb first on the test data input)
// ----------------------------------------------------------------------
`define CDM_FRAME_LEN   6'h28
`define CDM_DATA_LSB    0
`define CDM_DATA_MSB    31
`define CDM_IDX_LSB     32
`define CDM_IDX_MSB     35
`define CDM_OP_LSB      36
`define CDM_OP_MSB      39

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define CDM_OP_NOP      4'h0
`define CDM_OP_MODE     4'h1
`define CDM_OP_RESUME   4'h2
`define CDM_OP_STEP     4'h3
`define CDM_OP_REG_WR   4'h4
`define CDM_OP_REG_RD   4'h5
`define CDM_OP_FREEZE   4'h6
`define CDM_OP_HW_BP    4'h7
`define CDM_OP_SW_BP    4'h8
`define CDM_OP_IC_ADDR  4'h9
`define CDM_OP_IC_WR    4'hA

// ----------------------------------------------------------------------
// debug mode codes and reset values
// ----------------------------------------------------------------------
`define CDM_MODE_OFF    2'h0
`define CDM_MODE_INT    2'h1
`define CDM_MODE_EXT    2'h2
`define CDM_MODE_WAIT   2'h3
`define CDM_MODE_RST    2'h0
`define CDM_WORD_RST    32'h00000000

`endif

/* File: design/cdm_fifo.v */
// synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

module cdm_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk,
	input  wire             sys_rst,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW:0]      wr_q;
	reg [AW:0]      rd_q;

	wire full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	wire empty = (wr_q == rd_q);
	wire push  = in_valid && !full;
	wire pop   = out_ready && !empty;

	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem_q[rd_q[AW-1:0]];

	// ------------------------------------------------------------------
	// pointers carry one wrap bit so full and empty stay honest
	// ------------------------------------------------------------------
	always @(posedge clk) begin
		if (sys_rst) begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
		end
	end

	// storage needs no reset; empty masks stale words
	always @(posedge clk) begin
		if (push)
			mem_q[wr_q[AW-1:0]] <= in_data;
	end

endmodule // cdm_fifo

`default_nettype wire

/* File: sim/cdm_debug_ctrl_sva.sv */
// port checker for the debug controller
// assumes a bind onto cdm_debug_ctrl and a single clock domain
`timescale 1ns/1ps
`default_nettype none
module cdm_debug_ctrl_sva #(
	parameter TW = 32
) (
	input wire logic          clk,
	input wire logic          sys_rst,
	input wire logic          debug_event,
	input wire logic          irq_in,
	input wire logic          isr_done,
	input wire logic [1:0]    dbg_mode,
	input wire logic          core_halt,
	input wire logic          core_in_wait,
	input wire logic          dbg_exc,
	input wire logic          irq_take,
	input wire logic          trc_trigger,
	input wire logic          trc_valid,
	input wire logic          trc_ready,
	input wire logic [TW-1:0] trc_data,
	input wire logic          res_re,
	input wire logic          res_ack
);
	// ----
	// helper: inside interrupt service after leaving wait
	// ----
	logic isr_q;
	always_ff @(posedge clk) begin
		if (sys_rst || isr_done)
			isr_q <= 1'b0;
		else if (irq_take)
			isr_q <= 1'b1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_ext_stop: assert property (dbg_mode == 2'h2 && debug_event && !core_halt |=> core_halt)
		else $error("stop not entered");
	a_wait_enter: assert property (dbg_mode == 2'h3 && debug_event && !core_halt |=> core_in_wait)
		else $error("wait not entered");
	a_int_exc: assert property (dbg_mode == 2'h1 && debug_event && !core_halt |=> dbg_exc && !core_halt)
		else $error("no debug exception");
	a_trig_event: assert property (trc_trigger == ($past(debug_event) && $past(dbg_mode) != 2'h0))
		else $error("trace trigger wrong");
	a_wait_halt: assert property (core_in_wait |-> core_halt)
		else $error("wait state not halted");
	a_irq_leave: assert property (irq_take |-> !core_halt && $past(core_in_wait) && $past(irq_in))
		else $error("bad interrupt leave");
	a_isr_back: assert property (isr_q && isr_done |=> core_in_wait)
		else $error("no return to wait");
	a_trc_hold: assert property (trc_valid && !trc_ready |=> trc_valid && $stable(trc_data))
		else $error("trace word dropped");
	a_read_hold: assert property (res_re && !res_ack |=> res_re)
		else $error("read request dropped");
	a_off_quiet: assert property (dbg_mode == 2'h0 && debug_event && !core_halt |=> !core_halt && !dbg_exc)
		else $error("event acted while off");
	c_wait: cover property (core_in_wait);
	c_take: cover property (irq_take);
	c_exc: cover property (dbg_exc);
endmodule // cdm_debug_ctrl_sva
`default_nettype wire

/* File: sim/cdm_tool_model.sv */
// serial debug tool model: shifts frames lsb first, captures tdo
// assumes tck stands low between frames
`timescale 1ns/1ps
`default_nettype none
module cdm_tool_model (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input wire logic  tdo
);
	logic [39:0] rx_q;
	initial begin
		tck = 1'b0;
		tms = 1'b0;
		tdi = 1'b0;
	end
	// one frame; a count under 40 gives a frame the port must drop
	task automatic send(input logic [39:0] f, input int n);
		int i;
		tms = 1'b1;
		#250;
		for (i = 0; i < n; i++) begin
			tdi = f[i];
			#50;
			if (i > 0)
				rx_q[i-1] = tdo;
			tck = 1'b1;
			#62.5;
			tck = 1'b0;
			#12.5;
		end
		#50;
		rx_q[n-1] = tdo;
		tms = 1'b0;
		tdi = ~tdi; // released line must not keep its last value
		#250;
	endtask
endmodule // cdm_tool_model
`default_nettype wire

/* File: sim/test_cdm_debug_ctrl.sv */
// self-checking bench for the debug controller
// assumes the tool model on the serial port and a core stub here
`timescale 1ns/1ps
`default_nettype none
`include "cdm_debug_map.vh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module test_cdm_debug_ctrl;
	logic        clk, sys_rst, tck, tms, tdi, tdo, tdo_oe, debug_event, irq_in, isr_done;
	logic        insn_retired, core_halt, core_in_wait, dbg_exc, irq_take, timer_freeze;
	logic        res_we, res_re, res_ack, ack_dly, hw_bp_en, sw_bp_en, ic_we, trc_trigger;
	logic        trc_in_valid, trc_in_ready, trc_valid, trc_ready;
	logic [1:0]  dbg_mode;
	logic [3:0]  res_idx;
	logic [31:0] res_wdata, res_rdata, hw_bp_addr, ic_addr, ic_data, trc_in_data, trc_data;
	int          error_cnt, total_checks, n_exc, n_trg, n_take, n_we, n_icw, i, k;
	typedef struct {logic [3:0] op; logic [3:0] idx; logic [31:0] d; int sel; logic [31:0] e;} cdm_row_t;
	cdm_row_t rows[7] = '{
		'{`CDM_OP_MODE, 4'h0, 32'h2, 0, 32'h2},
		'{`CDM_OP_FREEZE, 4'h0, 32'h1, 1, 32'h1},
		'{`CDM_OP_HW_BP, 4'h1, 32'h100, 2, 32'h100},
		'{`CDM_OP_HW_BP, 4'h1, 32'h100, 5, 32'h1},
		'{`CDM_OP_SW_BP, 4'h0, 32'h1, 3, 32'h1},
		'{`CDM_OP_IC_ADDR, 4'h0, 32'h40, 4, 32'h40},
		'{`CDM_OP_FREEZE, 4'h0, 32'h0, 1, 32'h0}};
	cdm_debug_ctrl dut (
		.clk          (clk),
		.sys_rst      (sys_rst),
		.tck          (tck),
		.tms          (tms),
		.tdi          (tdi),
		.tdo          (tdo),
		.tdo_oe       (tdo_oe),
		.debug_event  (debug_event),
		.irq_in       (irq_in),
		.isr_done     (isr_done),
		.insn_retired (insn_retired),
		.core_halt    (core_halt),
		.core_in_wait (core_in_wait),
		.dbg_exc      (dbg_exc),
		.irq_take     (irq_take),
		.timer_freeze (timer_freeze),
		.dbg_mode     (dbg_mode),
		.res_we       (res_we),
		.res_re       (res_re),
		.res_idx      (res_idx),
		.res_wdata    (res_wdata),
		.res_rdata    (res_rdata),
		.res_ack      (res_ack),
		.hw_bp_en     (hw_bp_en),
		.hw_bp_addr   (hw_bp_addr),
		.sw_bp_en     (sw_bp_en),
		.ic_we        (ic_we),
		.ic_addr      (ic_addr),
		.ic_data      (ic_data),
		.trc_in_valid (trc_in_valid),
		.trc_in_ready (trc_in_ready),
		.trc_in_data  (trc_in_data),
		.trc_valid    (trc_valid),
		.trc_ready    (trc_ready),
		.trc_data     (trc_data),
		.trc_trigger  (trc_trigger)
	);
	cdm_tool_model tool (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// core stub: pulse counters; a read waits one cycle, so the held request is seen
	always @(negedge clk) begin
		ack_dly <= res_re && !res_ack;
		res_ack <= ack_dly && res_re && !res_ack;
		if (!sys_rst) begin
			n_exc  <= n_exc + dbg_exc;
			n_trg  <= n_trg + trc_trigger;
			n_take <= n_take + irq_take;
			n_we   <= n_we + res_we;
			n_icw  <= n_icw + ic_we;
		end
	end
	function automatic logic [31:0] pick(input int s);
		case (s)
			0: pick = {30'h0, dbg_mode};
			1: pick = {31'h0, timer_freeze};
			2: pick = hw_bp_addr;
			3: pick = {31'h0, sw_bp_en};
			4: pick = ic_addr;
			default: pick = {31'h0, hw_bp_en};
		endcase
	endfunction
	task automatic frame(input logic [3:0] op, input logic [3:0] idx, input logic [31:0] d);
		tool.send({op, idx, d}, 40);
		@(negedge clk);
	endtask
	// one-cycle debug event, then let the effects land
	task ev;
		@(negedge clk) debug_event = 1'b1;
		@(negedge clk) debug_event = 1'b0;
		repeat (4) @(negedge clk);
	endtask
	task results;
		$display("checks=%0d errors=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ----
	// main sequence
	// ----
	initial begin
		{debug_event, irq_in, isr_done, insn_retired, trc_in_valid} = 5'h00;
		res_rdata = 32'h12345678;
		trc_in_data = 32'h0;
		trc_ready = 1'b0;
		irq_in = 1'b0;
		sys_rst = 1'b1;
		repeat (4) @(negedge clk);
		sys_rst = 1'b0;
		@(negedge clk);
		`CHK({dbg_mode, core_halt, tdo_oe, trc_valid, trc_in_ready}, 6'h01)
		ev;
		`CHK({core_halt, n_trg[0]}, 2'b00)
		tool.send({`CDM_OP_MODE, 4'h0, 32'h2}, 39);
		@(negedge clk);
		`CHK(dbg_mode, `CDM_MODE_OFF)
		for (i = 0; i < 7; i++) begin
			frame(rows[i].op, rows[i].idx, rows[i].d);
			`CHK(pick(rows[i].sel), rows[i].e)
		end
		frame(`CDM_OP_IC_WR, 4'h0, 32'hDEADBEEF);
		frame(`CDM_OP_IC_WR, 4'h0, 32'hCAFE0001);
		`CHK({n_icw[1:0], ic_addr, ic_data}, {2'h2, 32'h48, 32'hCAFE0001})
		frame(`CDM_OP_MODE, 4'h0, 32'h1);
		ev;
		`CHK({n_exc[1:0], n_trg[1:0], core_halt}, 5'b01010)
		frame(`CDM_OP_MODE, 4'h0, 32'h2);
		ev;
		`CHK({core_halt, n_trg[1:0]}, 3'b110)
		frame(`CDM_OP_REG_WR, 4'h3, 32'hA5A50F0F);
		`CHK({n_we[1:0], res_idx, res_wdata}, {2'h1, 4'h3, 32'hA5A50F0F})
		frame(`CDM_OP_REG_RD, 4'h2, 32'h0);
		frame(`CDM_OP_NOP, 4'h0, 32'h0);
		`CHK({res_re, tool.rx_q[32:0]}, {2'b00, 32'h12345678})
		frame(`CDM_OP_STEP, 4'h0, 32'h0);
		`CHK(core_halt, 1'b0)
		@(negedge clk) insn_retired = 1'b1;
		@(negedge clk) insn_retired = 1'b0;
		repeat (3) @(negedge clk);
		`CHK(core_halt, 1'b1)
		frame(`CDM_OP_RESUME, 4'h0, 32'h0);
		`CHK(core_halt, 1'b0)
		frame(`CDM_OP_MODE, 4'h0, 32'h3);
		ev;
		`CHK({core_halt, core_in_wait}, 2'b11)
		repeat (20) @(negedge clk);
		`CHK({core_halt, core_in_wait}, 2'b11)
		irq_in = 1'b1;
		repeat (3) @(negedge clk);
		irq_in = 1'b0;
		`CHK({n_take[1:0], core_halt}, 3'b010)
		@(negedge clk) isr_done = 1'b1;
		@(negedge clk) isr_done = 1'b0;
		@(negedge clk);
		`CHK(core_in_wait, 1'b1)
		frame(`CDM_OP_RESUME, 4'h0, 32'h0);
		`CHK(core_halt, 1'b0)
		// fill with the sink stalled until refused, then drain in order
		k = 0;
		for (i = 0; i < 20 && trc_in_ready === 1'b1; i++) begin
			trc_in_valid = 1'b1;
			trc_in_data = 32'(i);
			@(negedge clk);
			k++;
		end
		trc_in_valid = 1'b0;
		`CHK({k, trc_in_ready}, {32'h10, 1'b0})
		trc_ready = 1'b1;
		for (i = 0; i < 16; i++) begin
			`CHK({trc_valid, trc_data}, {1'b1, 32'(i)})
			@(negedge clk);
		end
		`CHK(trc_valid, 1'b0)
		// second reset in mid-run: settings fall back, the port still works after it
		sys_rst = 1'b1;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		@(negedge clk);
		`CHK({dbg_mode, hw_bp_en, sw_bp_en, ic_addr, trc_in_ready}, {2'h0, 1'b0, 1'b0, 32'h0, 1'b1})
		frame(`CDM_OP_MODE, 4'h0, 32'h2);
		`CHK(dbg_mode, `CDM_MODE_EXT)
		results;
	end
endmodule // test_cdm_debug_ctrl
bind cdm_debug_ctrl cdm_debug_ctrl_sva #(.TW(TW)) u_sva (
	.clk          (clk),
	.sys_rst      (sys_rst),
	.debug_event  (debug_event),
	.irq_in       (irq_in),
	.isr_done     (isr_done),
	.dbg_mode     (dbg_mode),
	.core_halt    (core_halt),
	.core_in_wait (core_in_wait),
	.dbg_exc      (dbg_exc),
	.irq_take     (irq_take),
	.trc_trigger  (trc_trigger),
	.trc_valid    (trc_valid),
	.trc_ready    (trc_ready),
	.trc_data     (trc_data),
	.res_re       (res_re),
	.res_ack      (res_ack)
);
`default_nettype wire
